/* File: hdl/dvsr_pkg.sv */
package dvsr_pkg;
  // ==========================================================
  // Serial control word layout
  localparam int WORD_BITS = 16;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 9;
  localparam int UPDATE_BIT = 8;
  localparam int CODE_MSB = 7;
  localparam int ADDR_W = 7;
  localparam int CODE_W = 8;
  localparam int NUM_CH = 6;
  // ==========================================================
  // Register addresses
  localparam logic [6:0] ADDR_LEFT_OUT1 = 7'h00;
  localparam logic [6:0] ADDR_RIGHT_OUT1 = 7'h01;
  localparam logic [6:0] ADDR_LEFT_OUT2 = 7'h04;
  localparam logic [6:0] ADDR_RIGHT_OUT2 = 7'h05;
  localparam logic [6:0] ADDR_LEFT_OUT3 = 7'h06;
  localparam logic [6:0] ADDR_RIGHT_OUT3 = 7'h07;
  localparam logic [6:0] ADDR_ALL_CHANNEL = 7'h08;
  localparam logic [6:0] ADDR_SOFTWARE_RESET_TRIGGER = 7'h1F;
  // ==========================================================
  // Attenuation codes and reset values
  localparam logic [7:0] CODE_MUTE = 8'h00;
  localparam logic [7:0] CODE_FULL_SCALE = 8'hFF;
  localparam logic [7:0] CODE_RESET = 8'hFF;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
endpackage

/* File: hdl/dvsr_latch_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module dvsr_latch_mem #(
  parameter int N = 6,
  parameter int W = 8,
  parameter logic [7:0] INIT = 8'hFF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [N-1:0] wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [N*W-1:0] rd_data
);
  // ==========================================================
  // One intermediate latch per channel; clear beats a write
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_entry
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          rd_data[g*W +: W] <= INIT[W-1:0];
        end else if (clear) begin
          rd_data[g*W +: W] <= INIT[W-1:0];
        end else if (wr_en[g]) begin
          rd_data[g*W +: W] <= wr_data;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: hdl/dvsr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dvsr_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ctrl_clk,
  input wire logic ctrl_data,
  input wire logic ctrl_latch,
  input wire logic sample_clk,
  output logic [dvsr_pkg::NUM_CH*8-1:0] attenuation_steps_r,
  output logic [dvsr_pkg::NUM_CH-1:0] channel_mute_r,
  output logic [dvsr_pkg::NUM_CH*8-1:0] active_code_r,
  output logic soft_reset_hold_r
);
  import dvsr_pkg::*;

  // ==========================================================
  // Pin synchronisers; stage one feeds stage two only
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_s3_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      pin_s3_r <= 4'h0;
    end else begin
      pin_s1_r <= {sample_clk, ctrl_latch, ctrl_data, ctrl_clk};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Rising edges seen on the settled copies
  wire clk_rise = pin_s2_r[0] & ~pin_s3_r[0];
  wire latch_rise = pin_s2_r[2] & ~pin_s3_r[2];
  wire sample_rise = pin_s2_r[3] & ~pin_s3_r[3];
  wire data_bit = pin_s2_r[1];

  // ==========================================================
  // Serial shift register, MSB first, 16 bits per word
  logic [WORD_BITS-1:0] shift_r;
  logic [WORD_BITS-1:0] shift_nxt;
  assign shift_nxt = {shift_r[WORD_BITS-2:0], data_bit};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= SHIFT_RESET;
    end else if (clk_rise) begin
      shift_r <= shift_nxt;
    end
  end

  // ==========================================================
  // Word decode on the latch edge
  wire [ADDR_W-1:0] wr_addr = shift_r[ADDR_MSB:ADDR_LSB];
  wire [CODE_W-1:0] wr_code = shift_r[CODE_MSB:0];
  wire wr_update = shift_r[UPDATE_BIT];
  wire wr_done = latch_rise;
  wire is_reset_cmd = wr_addr == ADDR_SOFTWARE_RESET_TRIGGER;
  wire is_master = wr_addr == ADDR_ALL_CHANNEL;
  // Stores only when not held and not a reset command
  wire store_ok = wr_done & ~soft_reset_hold_r & ~is_reset_cmd;
  wire soft_reset = wr_done & is_reset_cmd;

  // One enable per channel address; master hits every channel
  logic [NUM_CH-1:0] addr_hit;
  assign addr_hit[0] = wr_addr == ADDR_LEFT_OUT1;
  assign addr_hit[1] = wr_addr == ADDR_RIGHT_OUT1;
  assign addr_hit[2] = wr_addr == ADDR_LEFT_OUT2;
  assign addr_hit[3] = wr_addr == ADDR_RIGHT_OUT2;
  assign addr_hit[4] = wr_addr == ADDR_LEFT_OUT3;
  assign addr_hit[5] = wr_addr == ADDR_RIGHT_OUT3;
  wire [NUM_CH-1:0] latch_we =
    {NUM_CH{store_ok}} & (addr_hit | {NUM_CH{is_master}});
  wire any_hit = |addr_hit | is_master;
  wire apply_req = store_ok & any_hit & wr_update;

  // ==========================================================
  // Intermediate latches, cleared by software reset
  logic [NUM_CH*CODE_W-1:0] pending_code;
  dvsr_latch_mem #(
    .N(NUM_CH),
    .W(CODE_W),
    .INIT(CODE_RESET)
  ) u_latch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(soft_reset),
    .wr_en(latch_we),
    .wr_data(wr_code),
    .rd_data(pending_code)
  );

  // ==========================================================
  // Hold flag: set by reset command, released by next write
  logic hold_nxt;
  assign hold_nxt = soft_reset ? 1'b1 :
                    (wr_done ? 1'b0 : soft_reset_hold_r);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_hold_r <= 1'b0;
    end else begin
      soft_reset_hold_r <= hold_nxt;
    end
  end

  // ==========================================================
  // Apply request waits for a sample boundary; a new request
  // arriving on the boundary cycle stays pending, since the
  // latch it just wrote is not visible until the next cycle
  logic apply_pend_r;
  logic apply_pend_nxt;
  wire apply_now = apply_pend_r & sample_rise;
  assign apply_pend_nxt = soft_reset ? 1'b0 :
                          (apply_req ? 1'b1 :
                          (apply_now ? 1'b0 : apply_pend_r));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      apply_pend_r <= 1'b0;
    end else begin
      apply_pend_r <= apply_pend_nxt;
    end
  end

  // ==========================================================
  // Active codes and their decode, per channel
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      wire [CODE_W-1:0] code_nxt =
        soft_reset ? CODE_RESET :
        (apply_now ? pending_code[c*CODE_W +: CODE_W] :
        active_code_r[c*CODE_W +: CODE_W]);
      // Half-dB steps below full scale; 01 gives 254 = 127 dB
      wire [CODE_W-1:0] steps_nxt = CODE_FULL_SCALE - code_nxt;
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          active_code_r[c*CODE_W +: CODE_W] <= CODE_RESET;
          attenuation_steps_r[c*CODE_W +: CODE_W] <= 8'h00;
          channel_mute_r[c] <= 1'b0;
        end else begin
          active_code_r[c*CODE_W +: CODE_W] <= code_nxt;
          attenuation_steps_r[c*CODE_W +: CODE_W] <= steps_nxt;
          channel_mute_r[c] <= code_nxt == CODE_MUTE;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: test/dvsr_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host driving the control and sample pins
module dvsr_host (
  input wire logic clk_sys,
  output logic ctrl_clk,
  output logic ctrl_data,
  output logic ctrl_latch,
  output logic sample_clk
);
  // Four cycles per level, above the three the port needs
  task automatic w4;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  // Word goes out MSB first, latch edge completes it
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      ctrl_data = w[i];
      w4;
      ctrl_clk = 1'b1;
      w4;
      ctrl_clk = 1'b0;
    end
    ctrl_latch = 1'b1;
    w4;
    ctrl_latch = 1'b0;
    ctrl_data = ~ctrl_data; // No stale bit left on the line
    w4;
  endtask
  // One sample boundary
  task automatic tick;
    sample_clk = 1'b1;
    w4;
    sample_clk = 1'b0;
    w4;
  endtask
  // Pins idle low
  initial begin
    ctrl_clk = 1'b0;
    ctrl_data = 1'b0;
    ctrl_latch = 1'b0;
    sample_clk = 1'b0;
  end
endmodule
`default_nettype wire

/* File: test/dvsr_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dvsr_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ctrl_latch,
  input wire logic sample_clk,
  input wire logic [47:0] attenuation_steps_r,
  input wire logic [5:0] channel_mute_r,
  input wire logic [47:0] active_code_r,
  input wire logic soft_reset_hold_r
);
  // ==========
  // Output relations
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence latch_seen;
    $past(ctrl_latch);
  endsequence
  function automatic logic [5:0] muted(logic [47:0] c);
    for (int i = 0; i < 6; i++)
      muted[i] = c[i*8 +: 8] == 8'h00;
  endfunction
  mute_map_a: assert property (
    channel_mute_r == muted(active_code_r))
    else $error("mute flags wrong");
  step_map_a: assert property (attenuation_steps_r == ~active_code_r)
    else $error("steps wrong");
  power_dflt_a: assert property (
    $rose(rst_n) |-> active_code_r == {6{8'hFF}})
    else $error("power defaults wrong");
  reset_dflt_a: assert property ($rose(soft_reset_hold_r) |->
    active_code_r == {6{8'hFF}}) else $error("soft defaults wrong");
  hold_entry_a: assert property ($rose(soft_reset_hold_r) |-> latch_seen)
    else $error("hold without write");
  hold_exit_a: assert property ($fell(soft_reset_hold_r) |-> latch_seen)
    else $error("hold left without write");
  hold_frozen_a: assert property (
    soft_reset_hold_r && $past(soft_reset_hold_r)
    |-> $stable(active_code_r)) else $error("codes moved in hold");
  apply_tick_a: assert property (
    $changed(active_code_r) && !soft_reset_hold_r
    |-> $past(sample_clk)) else $error("apply off boundary");
endmodule
bind dvsr_top dvsr_chk dvsr_chk_inst (.clk_sys, .rst_n, .ctrl_latch,
  .sample_clk, .attenuation_steps_r, .channel_mute_r, .active_code_r,
  .soft_reset_hold_r);
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dvsr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  wire ctrl_clk, ctrl_data, ctrl_latch, sample_clk;
  logic [47:0] steps, code;
  logic [5:0] mute;
  logic hold;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int lat[6] = '{default: 8'hFF};
  int act[6] = '{default: 8'hFF};
  int m_hold = 0;
  logic [16:0] lf = 17'h18568;
  logic [7:0] edg[4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
  logic [6:0] adr[10] = '{ADDR_LEFT_OUT1, ADDR_RIGHT_OUT1, ADDR_LEFT_OUT2,
    ADDR_RIGHT_OUT2, ADDR_LEFT_OUT3, ADDR_RIGHT_OUT3, ADDR_ALL_CHANNEL,
    ADDR_SOFTWARE_RESET_TRIGGER, 7'h02, 7'h1E};
  always #50 clk_sys = ~clk_sys;
  dvsr_top dvsr_top_inst (.clk_sys, .rst_n, .ctrl_clk, .ctrl_data,
    .ctrl_latch, .sample_clk, .attenuation_steps_r(steps),
    .channel_mute_r(mute), .active_code_r(code), .soft_reset_hold_r(hold));
  dvsr_host dvsr_host_inst (.clk_sys, .ctrl_clk, .ctrl_data, .ctrl_latch,
    .sample_clk);
  // ==========
  // Model and checks
  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_all;
    logic [47:0] ec, es;
    logic [5:0] em;
    for (int i = 0; i < 6; i++) begin
      ec[i*8 +: 8] = act[i][7:0];
      es[i*8 +: 8] = 8'hFF - act[i][7:0];
      em[i] = act[i] == 0;
    end
    cmp(code, ec);
    cmp(steps, es);
    cmp({42'h0, mute}, {42'h0, em});
    cmp({47'h0, hold}, {47'h0, m_hold[0]});
  endtask
  // Pending apply lands at the tick that always follows
  // Codes must not move before the boundary; a reset acts at once
  task automatic put(input logic [6:0] a, input logic u, input logic [7:0] c);
    int nxt[6];
    dvsr_host_inst.send({a, u, c});
    nxt = act;
    if (a == ADDR_SOFTWARE_RESET_TRIGGER) begin
      lat = '{default: 8'hFF};
      act = '{default: 8'hFF};
      nxt = act;
      m_hold = 1;
    end else if (m_hold)
      m_hold = 0;
    else begin
      for (int i = 0; i < 6; i++)
        if (a == adr[i] || a == ADDR_ALL_CHANNEL)
          lat[i] = c;
      if (u && (a == ADDR_ALL_CHANNEL || a < 7'h08 && a != 7'h02 && a != 7'h03))
        nxt = lat;
    end
    check_all;
    act = nxt;
    dvsr_host_inst.tick;
  endtask
  task automatic summarize;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      summarize;
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    dvsr_host_inst.w4;
    check_all;
    for (int n = 0; n < 40; n++) begin
      lf = nx(lf);
      put(adr[n < 4 ? 6 : n % 8 == 4 ? 7 : lf % 10], n < 4 | lf[8],
        n < 4 ? edg[n] : lf[7:0]);
      check_all;
    end
    summarize;
  end
endmodule
`default_nettype wire
